//--- hw/exec_pkg.sv
// shared types, constants and helpers for the compare, skip and branch execution block
package exec_pkg;
   localparam int          PC_W             = 16;
   localparam int          OFF_W            = 7;
   localparam logic [15:0] PC_STEP          = 16'h0001;
   localparam logic [1:0]  SKIP_WORDS_ONE   = 2'h2;
   localparam logic [1:0]  SKIP_WORDS_TWO   = 2'h3;
   localparam logic [1:0]  ONE_CYC          = 2'h1;
   localparam logic [1:0]  BRANCH_TAKEN_CYC = 2'h2;
   localparam logic [7:0]  FLAGS_RESET      = 8'h00;

   typedef enum logic [3:0] {
      op_none, op_compare_skip_equal, op_compare_regs, op_compare_with_carry_in,
      op_compare_immediate, op_skip_reg_bit_clear, op_skip_reg_bit_set,
      op_skip_io_bit_clear, op_skip_io_bit_set, op_branch_flag_set,
      op_branch_flag_clear, op_branch_equal, op_branch_not_equal, op_branch_carry_clear
   } op_e;

   typedef enum logic {st_idle, st_stall} exec_st_e;

   // bit 7 down to bit 0
   typedef struct packed {
      logic i;
      logic t;
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } status_flags_s;

   typedef struct packed {
      logic [7:0]       dst;
      logic [7:0]       source_operand;
      logic [7:0]       imm;
      logic [7:0]       io_val;
      logic [2:0]       bit_sel;
      logic [2:0]       flag_sel;
      logic [OFF_W-1:0] offset;
      logic             next_two_word;
   } operands_s;

   typedef struct packed {
      exec_st_e      st;
      logic [1:0]    cnt;
      logic [PC_W-1:0] pc;
      status_flags_s flags;
      logic          wr_flags;
      logic          done;
      logic          flags_we;
      logic          busy;
   } exec_state_s;

   function automatic logic [1:0] skip_len(input logic two_word);
      skip_len = two_word ? SKIP_WORDS_TWO : SKIP_WORDS_ONE;
   endfunction : skip_len

   function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                     input logic [OFF_W-1:0] k);
      branch_target = pc + PC_STEP + {{(PC_W-OFF_W){k[OFF_W-1]}}, k};
   endfunction : branch_target
endpackage : exec_pkg

//--- hw/compare_flag_unit.sv
// subtract-and-flag unit shared by the three compare instructions
`timescale 1ns/10ps
module compare_flag_unit (
   input  wire logic [7:0]             dst,
   input  wire logic [7:0]             subtr,
   input  wire logic                   cin,
   input  wire exec_pkg::status_flags_s flags_in,
   output exec_pkg::status_flags_s     flags_out
);
   import exec_pkg::*;

   logic [8:0] diff;

   // only z, n, v, c and h move; s, t and i pass through untouched
   always_comb begin
      diff = {1'b0, dst} - {1'b0, subtr} - {8'h00, cin};
      flags_out = flags_in;
      flags_out.z = (diff[7:0] == 8'h00);
      flags_out.n = diff[7];
      flags_out.v = (dst[7] & ~subtr[7] & ~diff[7]) | (~dst[7] & subtr[7] & diff[7]);
      flags_out.c = diff[8];
      flags_out.h = (~dst[3] & subtr[3]) | (subtr[3] & diff[3]) | (diff[3] & ~dst[3]);
   end
endmodule : compare_flag_unit

//--- hw/compare_skip_branch_exec.sv
// execution of compare, skip-if and conditional branch instructions
`timescale 1ns/10ps
module compare_skip_branch_exec (
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      ce,
   input  wire logic                      issue,
   input  wire exec_pkg::op_e             op,
   input  wire exec_pkg::operands_s       opnd,
   input  wire logic [exec_pkg::PC_W-1:0] pc_in,
   input  wire exec_pkg::status_flags_s   flags_in,
   output logic                           busy,
   output logic                           done,
   output logic [exec_pkg::PC_W-1:0]      pc_out,
   output exec_pkg::status_flags_s        flags_out,
   output logic                           flags_we
);
   import exec_pkg::*;

   logic          rst_meta_n;
   logic          rst_n;
   exec_state_s   s_q;
   exec_state_s   s_d;
   status_flags_s cmp_flags;
   logic [7:0]    subtr;
   logic          cin;
   logic          start;
   logic          is_cmp;

   // reset released through two flops so all state leaves reset on one edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   assign subtr = (op == op_compare_immediate) ? opnd.imm : opnd.source_operand;
   assign cin   = (op == op_compare_with_carry_in) ? flags_in.c : 1'b0;
   assign is_cmp = (op == op_compare_regs) || (op == op_compare_with_carry_in)
                   || (op == op_compare_immediate);
   assign start = ce && issue && (s_q.st == st_idle);

   compare_flag_unit u_cmp (
      .dst       (opnd.dst),
      .subtr     (subtr),
      .cin       (cin),
      .flags_in  (flags_in),
      .flags_out (cmp_flags)
   );

   always_comb begin
      logic       take;
      logic [1:0] cyc;
      take = 1'b0;
      cyc  = ONE_CYC;
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.flags_we = 1'b0;
      case (s_q.st)
         st_idle: begin
            if (issue) begin
               s_d.pc = pc_in + PC_STEP;
               s_d.flags = flags_in;
               s_d.wr_flags = 1'b0;
               case (op)
                  op_compare_regs, op_compare_with_carry_in, op_compare_immediate: begin
                     s_d.flags = cmp_flags;
                     s_d.wr_flags = 1'b1;
                  end
                  op_compare_skip_equal: take = (opnd.dst == opnd.source_operand);
                  op_skip_reg_bit_clear: take = ~opnd.source_operand[opnd.bit_sel];
                  op_skip_reg_bit_set:   take = opnd.source_operand[opnd.bit_sel];
                  op_skip_io_bit_clear:  take = ~opnd.io_val[opnd.bit_sel];
                  op_skip_io_bit_set:    take = opnd.io_val[opnd.bit_sel];
                  op_branch_flag_set:    take = flags_in[opnd.flag_sel];
                  op_branch_flag_clear:  take = ~flags_in[opnd.flag_sel];
                  op_branch_equal:       take = flags_in.z;
                  op_branch_not_equal:   take = ~flags_in.z;
                  op_branch_carry_clear: take = ~flags_in.c;
                  default:               take = 1'b0;
               endcase
               if (take) begin
                  if (op >= op_branch_flag_set) begin
                     s_d.pc = branch_target(pc_in, opnd.offset);
                     cyc = BRANCH_TAKEN_CYC;
                  end else begin
                     // skip cost in cycles equals the PC advance, one more than the words skipped
                     s_d.pc = pc_in + PC_W'(skip_len(opnd.next_two_word));
                     cyc = skip_len(opnd.next_two_word);
                  end
               end
               if (cyc == ONE_CYC) begin
                  s_d.done = 1'b1;
                  s_d.flags_we = s_d.wr_flags;
               end else begin
                  s_d.st = st_stall;
                  s_d.cnt = cyc - ONE_CYC;
                  s_d.busy = 1'b1;
               end
            end
         end
         st_stall: begin
            if (s_q.cnt == ONE_CYC) begin
               s_d.st = st_idle;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.flags_we = s_q.wr_flags;
            end else begin
               s_d.cnt = s_q.cnt - ONE_CYC;
            end
         end
         default: s_d.st = st_idle;
      endcase
   end

   // ce low holds everything, so done may stand longer than one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: st_idle, cnt: 2'h0, pc: 16'h0000, flags: FLAGS_RESET, wr_flags: 1'b0,
                  done: 1'b0, flags_we: 1'b0, busy: 1'b0};
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign busy      = s_q.busy;
   assign done      = s_q.done;
   assign pc_out    = s_q.pc;
   assign flags_out = s_q.flags;
   assign flags_we  = s_q.flags_we;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_ce1;
      ##1 ce;
   endsequence
   sequence s_ce2;
      ##1 ce [*2];
   endsequence

   property p_skip_eq;
      (start && op == op_compare_skip_equal && opnd.dst == opnd.source_operand
       && !opnd.next_two_word) ##0 s_ce1
      |=> done && !flags_we && pc_out == $past(pc_in, 2) + 16'h0002;
   endproperty
   a_skip_eq: assert property (p_skip_eq) else $error("equal skip wrong");

   property p_cmp;
      start && op == op_compare_regs |=> done && flags_we
         && flags_out.z == ($past(opnd.dst) == $past(opnd.source_operand))
         && flags_out.c == ($past(opnd.dst) < $past(opnd.source_operand))
         && flags_out.s == $past(flags_in.s);
   endproperty
   a_cmp: assert property (p_cmp) else $error("register compare flags wrong");

   property p_cmpc;
      start && op == op_compare_with_carry_in |=> flags_we
         && flags_out.c == ({1'b0, $past(opnd.dst)}
                            < {1'b0, $past(opnd.source_operand)} + {8'h00, $past(flags_in.c)});
   endproperty
   a_cmpc: assert property (p_cmpc) else $error("carry compare flags wrong");

   property p_cmpi;
      start && op == op_compare_immediate |=> flags_we && pc_out == $past(pc_in) + 16'h0001
         && flags_out.z == ($past(opnd.dst) == $past(opnd.imm))
         && flags_out.n == ((($past(opnd.dst) - $past(opnd.imm)) & 8'h80) != 8'h00);
   endproperty
   a_cmpi: assert property (p_cmpi) else $error("immediate compare flags wrong");

   property p_srbc;
      (start && op == op_skip_reg_bit_clear && !opnd.source_operand[opnd.bit_sel]
       && !opnd.next_two_word) ##0 s_ce1 |=> done && pc_out == $past(pc_in, 2) + 16'h0002;
   endproperty
   a_srbc: assert property (p_srbc) else $error("register bit clear skip wrong");

   property p_srbs;
      start && op == op_skip_reg_bit_set && !opnd.source_operand[opnd.bit_sel]
      |=> done && pc_out == $past(pc_in) + 16'h0001;
   endproperty
   a_srbs: assert property (p_srbs) else $error("register bit set fell wrong");

   property p_sibc;
      start && op == op_skip_io_bit_clear && opnd.io_val[opnd.bit_sel]
      |=> done && !busy && pc_out == $past(pc_in) + 16'h0001;
   endproperty
   a_sibc: assert property (p_sibc) else $error("io bit clear fell wrong");

   property p_noflags;
      // a back-to-back compare may follow a one-cycle op, so only stalled cycles are held to zero
      start && !is_cmp |=> !flags_we ##1 (!$past(busy) || !flags_we)
                           ##1 (!$past(busy) || !flags_we);
   endproperty
   a_noflags: assert property (p_noflags) else $error("flags written by skip or branch");

   property p_bset;
      (start && op == op_branch_flag_set && flags_in[opnd.flag_sel]) ##0 s_ce1
      |=> done && pc_out == $past(pc_in, 2) + 16'h0001
          + {{9{$past(opnd.offset[6], 2)}}, $past(opnd.offset, 2)};
   endproperty
   a_bset: assert property (p_bset) else $error("flag set branch target wrong");

   property p_bclr;
      start && op == op_branch_flag_clear && flags_in[opnd.flag_sel]
      |=> done && pc_out == $past(pc_in) + 16'h0001;
   endproperty
   a_bclr: assert property (p_bclr) else $error("flag clear branch taken wrongly");

   property p_beq;
      start && op == op_branch_equal && flags_in.z |=> busy && !done;
   endproperty
   a_beq: assert property (p_beq) else $error("equal branch not taken");

   property p_bne;
      start && op == op_branch_not_equal && flags_in.z
      |=> done && !flags_we && pc_out == $past(pc_in) + 16'h0001;
   endproperty
   a_bne: assert property (p_bne) else $error("not equal branch fell wrong");

   property p_bcc;
      (start && op == op_branch_carry_clear && !flags_in.c) ##0 s_ce1
      |=> done && !busy && pc_out == $past(pc_in, 2) + 16'h0001
          + {{9{$past(opnd.offset[6], 2)}}, $past(opnd.offset, 2)};
   endproperty
   a_bcc: assert property (p_bcc) else $error("carry clear branch wrong");

   property p_two;
      (start && op == op_skip_io_bit_set && opnd.io_val[opnd.bit_sel]
       && opnd.next_two_word) ##0 s_ce2
      |=> done && pc_out == $past(pc_in, 3) + 16'h0003;
   endproperty
   a_two: assert property (p_two) else $error("two word skip wrong");

   property p_neg;
      (start && op == op_branch_not_equal && !flags_in.z && opnd.offset == 7'h7F) ##0 s_ce1
      |=> pc_out == $past(pc_in, 2);
   endproperty
   a_neg: assert property (p_neg) else $error("negative offset wrong");
endmodule : compare_skip_branch_exec

//--- test/tb_compare_skip_branch_exec.sv
// self-checking bench for the compare, skip and branch execution block
`timescale 1ns/10ps
module tb_compare_skip_branch_exec;
   import exec_pkg::*;
   logic                 clk;
   logic                 nrst;
   logic                 ce;
   logic                 issue;
   op_e                  op;
   operands_s            opnd;
   logic [PC_W-1:0]      pc_in;
   status_flags_s        flags_in;
   logic                 busy;
   logic                 done;
   logic [PC_W-1:0]      pc_out;
   status_flags_s        flags_out;
   logic                 flags_we;
   int                   num_errors;
   int                   tests_run;
   operands_s            od;

   compare_skip_branch_exec dut (
      .clk       (clk),
      .nrst      (nrst),
      .ce        (ce),
      .issue     (issue),
      .op        (op),
      .opnd      (opnd),
      .pc_in     (pc_in),
      .flags_in  (flags_in),
      .busy      (busy),
      .done      (done),
      .pc_out    (pc_out),
      .flags_out (flags_out),
      .flags_we  (flags_we)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic report_and_stop();
      if (num_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // reference subtract; carry and half carry worked out as integer borrows
   function automatic status_flags_s cmp_flags(input logic [7:0] d, input logic [7:0] s,
                                               input logic cin, input status_flags_s f);
      logic [7:0]    r;
      status_flags_s o;
      r   = d - s - {7'h00, cin};
      o   = f;
      o.z = (r == 8'h00);
      o.n = r[7];
      o.v = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
      o.c = (int'(d) < int'(s) + int'(cin));
      o.h = (int'(d[3:0]) < int'(s[3:0]) + int'(cin));
      return o;
   endfunction : cmp_flags

   task automatic run(input op_e o, input operands_s d, input logic [15:0] p,
                      input status_flags_s f, input int hold);
      logic [15:0]   epc;
      status_flags_s ef;
      logic [7:0]    sub;
      logic          cin;
      logic          tk;
      int            kind;
      int            cyc;
      int            n;
      tk   = 1'b0;
      kind = 0;
      sub  = d.source_operand;
      cin  = 1'b0;
      case (o)
         op_compare_regs:          kind = 1;
         op_compare_with_carry_in: begin kind = 1; cin = f.c; end
         op_compare_immediate:     begin kind = 1; sub = d.imm; end
         op_compare_skip_equal:    begin kind = 2; tk = (d.dst == d.source_operand); end
         op_skip_reg_bit_clear:    begin kind = 2; tk = !d.source_operand[d.bit_sel]; end
         op_skip_reg_bit_set:      begin kind = 2; tk = d.source_operand[d.bit_sel]; end
         op_skip_io_bit_clear:     begin kind = 2; tk = !d.io_val[d.bit_sel]; end
         op_skip_io_bit_set:       begin kind = 2; tk = d.io_val[d.bit_sel]; end
         op_branch_flag_set:       begin kind = 3; tk = f[d.flag_sel]; end
         op_branch_flag_clear:     begin kind = 3; tk = !f[d.flag_sel]; end
         op_branch_equal:          begin kind = 3; tk = f.z; end
         op_branch_not_equal:      begin kind = 3; tk = !f.z; end
         op_branch_carry_clear:    begin kind = 3; tk = !f.c; end
         default:                  kind = 0;
      endcase
      epc = p + 16'h0001;
      cyc = 1;
      ef  = (kind == 1) ? cmp_flags(d.dst, sub, cin, f) : f;
      if (tk && kind == 2) begin
         cyc = d.next_two_word ? 3 : 2;
         epc = p + cyc[15:0];
      end
      if (tk && kind == 3) begin
         cyc = 2;
         epc = p + 16'h0001 + {{9{d.offset[6]}}, d.offset};
      end
      if (cyc > 1) begin
         // each low cycle of ce freezes a stall for one more edge
         cyc = cyc + hold;
      end
      @(posedge clk);
      ce       <= 1'b1;
      issue    <= 1'b1;
      op       <= o;
      opnd     <= d;
      pc_in    <= p;
      flags_in <= f;
      @(posedge clk);
      issue <= 1'b0;
      ce    <= (hold == 0);
      // a one-cycle result stands only until the next edge with ce high, so look right after the issue edge
      #1;
      n = 1;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         if (n == hold) begin
            ce <= 1'b1;
         end
         #1;
         n++;
      end
      chk("done_cycles", cyc[15:0], n[15:0]);
      if (kind == 3) begin
         chk("branch_pc", epc, pc_out);
      end else if (kind == 2) begin
         chk("skip_pc", epc, pc_out);
      end else begin
         chk("next_pc", epc, pc_out);
      end
      chk("flags_we", {15'h0000, kind == 1}, {15'h0000, flags_we});
      chk("flags_out", {8'h00, ef}, {8'h00, flags_out});
   endtask : run

   task automatic reset_dut();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("reset_outputs", 16'h0000, {12'h000, busy, done, flags_we, |flags_out});
      chk("reset_pc", 16'h0000, pc_out);
      @(posedge clk);
      nrst <= 1'b1;
      // synchroniser needs two edges before the first request is honoured
      repeat (3) @(posedge clk);
   endtask : reset_dut

   initial begin
      num_errors = 0;
      tests_run  = 0;
      nrst       = 1'b0;
      ce         = 1'b1;
      issue      = 1'b0;
      op         = op_none;
      opnd       = '0;
      pc_in      = 16'h0000;
      flags_in   = FLAGS_RESET;
      void'($urandom(32'hF24AAC86));
      reset_dut();
      // offset boundaries, program counter wrap, a carry-in compare and a skip stalled by ce low
      od = '0;
      od.offset = 7'h40;
      run(op_branch_equal, od, 16'h0010, 8'h02, 0);
      od.offset = 7'h3F;
      run(op_branch_carry_clear, od, 16'hFFFF, 8'h00, 0);
      od.next_two_word = 1'b1;
      run(op_compare_skip_equal, od, 16'hFFFE, 8'hFF, 0);
      od.dst = 8'h00;
      od.source_operand = 8'h01;
      run(op_compare_with_carry_in, od, 16'h1234, 8'h01, 0);
      od.offset = 7'h7F;
      run(op_branch_not_equal, od, 16'h2000, 8'h00, 0);
      od.io_val = 8'h00;
      run(op_skip_io_bit_clear, od, 16'h0200, 8'h00, 2);
      for (int i = 0; i < 400; i++) begin
         od = operands_s'({$urandom, $urandom});
         if ($urandom_range(0, 3) == 0) begin
            od.source_operand = od.dst;
         end
         run(op_e'($urandom_range(0, 13)), od, 16'($urandom), status_flags_s'(8'($urandom)),
             ($urandom_range(0, 3) == 0) ? 2 : 0);
      end
      reset_dut();
      run(op_compare_regs, od, 16'h0100, 8'hA5, 0);
      report_and_stop();
   end

   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end
endmodule : tb_compare_skip_branch_exec
